// File: design/dual_async_serial_port.sv
// two-channel asynchronous serial port with modem lines
// Summary of operation
// - write strobe with select loads addressed register
// - read strobe with select drives addressed register
// - read-select output high during host reads
// - reset idles all outputs and clears registers, except transmit-empty pending, which it sets
// - serial paths idle during reset
// - characters travel least significant bit first
// - start, optional parity, stop bits framed
// - output at mark in reset, loopback, and idle while the break bit is clear
// - control bit 0 drives terminal-ready low
// - control bit 1 drives request-to-send low
// - handshake pins never gate serial traffic
// - clear-to-send readable at status bit 4
// - loopback feeds transmitter into receiver
// - high line is one, low is zero
// - enabled events raise channel interrupt
// - character length five to eight bits
// - even, odd or no parity
// - programmable divisor sets bit rate
// - eight-bit bus, three address lines
// - divisor bytes at codes 0 and 1
`timescale 1ns/1ps
module dual_async_serial_port
    import uart_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] hostAddr,
    input wire logic hostWriteStrobeN,
    input wire logic hostReadStrobeN,
    input wire logic [CHANNELS-1:0] chipSelN,
    input wire logic [7:0] writeData,
    output logic [7:0] readData,
    output logic readDataEn,
    output logic readSelectOut,
    input wire logic [CHANNELS-1:0] serialRx,
    output logic [CHANNELS-1:0] serialTx,
    input wire logic [CHANNELS-1:0] ctsN,
    input wire logic [CHANNELS-1:0] dsrN,
    input wire logic [CHANNELS-1:0] riN,
    input wire logic [CHANNELS-1:0] cdN,
    output logic [CHANNELS-1:0] dtrN,
    output logic [CHANNELS-1:0] rtsN,
    output logic [CHANNELS-1:0] irq
);
    logic [CHANNELS-1:0] writeAct;
    logic [CHANNELS-1:0] readAct;
    logic [CHANNELS-1:0] wrPrev_r;
    logic [CHANNELS-1:0] rdPrev_r;
    logic [CHANNELS-1:0] wrStart;
    logic [CHANNELS-1:0] rdStart;
    logic [7:0] rdData [CHANNELS];
    logic [7:0] rdSel;
    logic [7:0] readData_r;

    assign writeAct = ~chipSelN & {CHANNELS{~hostWriteStrobeN}};
    assign readAct = ~chipSelN & {CHANNELS{~hostReadStrobeN}};
    assign wrStart = writeAct & ~wrPrev_r;
    assign rdStart = readAct & ~rdPrev_r;
    assign readDataEn = |readAct;
    assign readSelectOut = |readAct;
    assign readData = readData_r;

    always_comb
    begin
        rdSel = 8'h00;
        for (int i = 0; i < CHANNELS; i++)
            if (rdStart[i])
                rdSel = rdData[i];
    end

    // value frozen at the start of a read so side effects do not alter it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wrPrev_r <= '0;
            rdPrev_r <= '0;
            readData_r <= 8'h00;
        end
        else
        begin
            wrPrev_r <= writeAct;
            rdPrev_r <= readAct;
            if (|rdStart)
                readData_r <= rdSel;
        end
    end

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : chan
        logic [3:0] ier_r;
        logic [7:0] lcr_r;
        logic [4:0] mcr_r;
        logic [7:0] scr_r;
        logic [15:0] div_r;
        logic [15:0] baudCnt_r;
        logic [15:0] baudCnt_nxt;
        logic tick;
        logic [7:0] thr_r;
        logic thrFull_r;
        logic thrIntPend_r;
        logic [7:0] rhr_r;
        logic dataReady_r;
        logic overrun_r;
        logic parityErr_r;
        logic frameErr_r;
        logic breakInt_r;
        logic [3:0] modemNow;
        logic [3:0] modemPrev_r;
        logic [3:0] modemChange;
        logic [3:0] msrDelta_r;
        logic irq_r;
        logic lineOut_r;
        txState_t txState_r;
        logic [3:0] txTick_r;
        logic [2:0] txBit_r;
        logic [7:0] txShift_r;
        logic txPar_r;
        logic txStop_r;
        logic txLevel;
        logic txBitEnd;
        logic txLoad;
        rxState_t rxState_r;
        logic [3:0] rxTick_r;
        logic [2:0] rxBit_r;
        logic [7:0] rxShift_r;
        logic rxParBad_r;
        logic rxIn;
        logic rxBitEnd;
        logic rxDone;
        logic [7:0] rxData;
        logic [2:0] lastBit;
        logic dlab;
        logic [7:0] isrCode;
        logic [7:0] lsr;
        logic wrDiv;
        logic wrThr;
        logic rhrRd;
        logic lsrRd;
        logic msrRd;
        logic isrRd;

        assign dlab = lcr_r[LCR_DLAB];
        assign wrDiv = wrStart[ch] && dlab && hostAddr[2:1] == 2'h0;
        assign wrThr = wrStart[ch] && !dlab && hostAddr == ADDR_DATA;
        assign rhrRd = rdStart[ch] && !dlab && hostAddr == ADDR_DATA;
        assign lsrRd = rdStart[ch] && hostAddr == ADDR_LSR;
        assign msrRd = rdStart[ch] && hostAddr == ADDR_MSR;
        assign isrRd = rdStart[ch] && hostAddr == ADDR_ISR;
        assign lastBit = 3'h4 + {1'b0, lcr_r[1:0]};

        // configuration registers
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                ier_r <= IER_RESET;
                lcr_r <= LCR_RESET;
                mcr_r <= MCR_RESET;
                scr_r <= 8'h00;
                div_r <= DIV_RESET;
            end
            else if (wrDiv)
            begin
                if (hostAddr[0])
                    div_r[15:8] <= writeData;
                else
                    div_r[7:0] <= writeData;
            end
            else if (wrStart[ch])
            begin
                if (hostAddr == ADDR_IER)
                    ier_r <= writeData[3:0];
                else if (hostAddr == ADDR_LCR)
                    lcr_r <= writeData;
                else if (hostAddr == ADDR_MCR)
                    mcr_r <= writeData[4:0];
                else if (hostAddr == ADDR_SCR)
                    scr_r <= writeData;
            end
        end

        // divisor zero stops the tick
        assign baudCnt_nxt = (baudCnt_r <= 16'h0001) ? div_r : baudCnt_r - 16'h0001;
        assign tick = baudCnt_r == 16'h0001;

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
                baudCnt_r <= DIV_RESET;
            else
                baudCnt_r <= baudCnt_nxt;
        end

        // transmitter
        assign txLoad = txState_r == TX_IDLE && thrFull_r;
        assign txBitEnd = tick && txTick_r == BIT_LAST;
        assign txLevel = (txState_r == TX_START) ? 1'b0 :
                         (txState_r == TX_DATA) ? txShift_r[0] :
                         (txState_r == TX_PARITY) ? txPar_r : 1'b1;

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                txState_r <= TX_IDLE;
                txTick_r <= 4'h0;
                txBit_r <= 3'h0;
                txShift_r <= 8'h00;
                txPar_r <= 1'b0;
                txStop_r <= 1'b0;
            end
            else
            begin
                if (tick)
                    txTick_r <= txTick_r + 4'h1;
                case (txState_r)
                    TX_IDLE:
                        if (txLoad)
                        begin
                            txShift_r <= thr_r;
                            txPar_r <= parityBit(thr_r, lcr_r);
                            txTick_r <= 4'h0;
                            txState_r <= TX_START;
                        end
                    TX_START:
                        if (txBitEnd)
                        begin
                            txBit_r <= 3'h0;
                            txState_r <= TX_DATA;
                        end
                    TX_DATA:
                        if (txBitEnd)
                        begin
                            txShift_r <= {1'b0, txShift_r[7:1]};
                            txBit_r <= txBit_r + 3'h1;
                            txStop_r <= lcr_r[LCR_STOP];
                            if (txBit_r == lastBit)
                                txState_r <= lcr_r[LCR_PEN] ? TX_PARITY : TX_STOP;
                        end
                    TX_PARITY:
                        if (txBitEnd)
                            txState_r <= TX_STOP;
                    TX_STOP:
                        if (txBitEnd)
                        begin
                            txStop_r <= 1'b0;
                            if (!txStop_r)
                                txState_r <= TX_IDLE;
                        end
                    default:
                        txState_r <= TX_IDLE;
                endcase
            end
        end

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
                lineOut_r <= 1'b1;
            else if (mcr_r[MCR_LOOP])
                lineOut_r <= 1'b1;
            else
                lineOut_r <= txLevel & ~lcr_r[LCR_BREAK];
        end
        assign serialTx[ch] = lineOut_r;

        // receiver
        assign rxIn = mcr_r[MCR_LOOP] ? txLevel : serialRx[ch];
        assign rxBitEnd = tick && rxTick_r == BIT_LAST;
        assign rxDone = rxState_r == RX_STOP && rxBitEnd;
        assign rxData = (rxShift_r >> (2'h3 - lcr_r[1:0])) & charMask(lcr_r[1:0]);

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                rxState_r <= RX_IDLE;
                rxTick_r <= 4'h0;
                rxBit_r <= 3'h0;
                rxShift_r <= 8'h00;
                rxParBad_r <= 1'b0;
            end
            else
            begin
                if (tick)
                    rxTick_r <= rxTick_r + 4'h1;
                case (rxState_r)
                    RX_IDLE:
                        if (tick && !rxIn)
                        begin
                            rxTick_r <= 4'h0;
                            rxState_r <= RX_START;
                        end
                    RX_START:
                        if (tick && rxTick_r == SAMPLE_MID)
                        begin
                            // glitch shorter than half a bit is dropped
                            rxTick_r <= 4'h0;
                            rxBit_r <= 3'h0;
                            rxParBad_r <= 1'b0;
                            rxState_r <= rxIn ? RX_IDLE : RX_DATA;
                        end
                    RX_DATA:
                        if (rxBitEnd)
                        begin
                            rxShift_r <= {rxIn, rxShift_r[7:1]};
                            rxBit_r <= rxBit_r + 3'h1;
                            if (rxBit_r == lastBit)
                                rxState_r <= lcr_r[LCR_PEN] ? RX_PARITY : RX_STOP;
                        end
                    RX_PARITY:
                        if (rxBitEnd)
                        begin
                            rxParBad_r <= rxIn != parityBit(rxData, lcr_r);
                            rxState_r <= RX_STOP;
                        end
                    RX_STOP:
                        if (rxBitEnd)
                            rxState_r <= RX_IDLE;
                    default:
                        rxState_r <= RX_IDLE;
                endcase
            end
        end

        // modem status, with loopback echoing the control bits
        assign modemNow = mcr_r[MCR_LOOP] ?
            {mcr_r[MCR_OUT2], mcr_r[MCR_OUT1], mcr_r[MCR_DTR], mcr_r[MCR_RTS]} :
            ~{cdN[ch], riN[ch], dsrN[ch], ctsN[ch]};
        assign modemChange = {modemNow[3] ^ modemPrev_r[3],
                              modemPrev_r[2] & ~modemNow[2],
                              modemNow[1] ^ modemPrev_r[1],
                              modemNow[0] ^ modemPrev_r[0]};

        // status flags; a new event wins over a clearing read
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                thr_r <= 8'h00;
                thrFull_r <= 1'b0;
                thrIntPend_r <= 1'b1;
                rhr_r <= 8'h00;
                dataReady_r <= 1'b0;
                overrun_r <= 1'b0;
                parityErr_r <= 1'b0;
                frameErr_r <= 1'b0;
                breakInt_r <= 1'b0;
                modemPrev_r <= 4'h0;
                msrDelta_r <= 4'h0;
            end
            else
            begin
                if (wrThr)
                    thr_r <= writeData;
                thrFull_r <= wrThr | (thrFull_r & ~txLoad);
                thrIntPend_r <= txLoad |
                    (thrIntPend_r & ~wrThr & ~(isrRd && isrCode == ISR_THRE));
                if (rxDone)
                    rhr_r <= rxData;
                dataReady_r <= rxDone | (dataReady_r & ~rhrRd);
                overrun_r <= (rxDone & dataReady_r) | (overrun_r & ~lsrRd);
                parityErr_r <= (rxDone & rxParBad_r) | (parityErr_r & ~lsrRd);
                frameErr_r <= (rxDone & ~rxIn) | (frameErr_r & ~lsrRd);
                breakInt_r <= (rxDone & ~rxIn & rxData == 8'h00) | (breakInt_r & ~lsrRd);
                modemPrev_r <= modemNow;
                msrDelta_r <= modemChange | (msrDelta_r & ~{4{msrRd}});
            end
        end

        assign lsr = {1'b0, txState_r == TX_IDLE && !thrFull_r, ~thrFull_r,
                      breakInt_r, frameErr_r, parityErr_r, overrun_r, dataReady_r};
        assign isrCode =
            (ier_r[IER_LS] && |lsr[4:1]) ? ISR_LS :
            (ier_r[IER_RX] && dataReady_r) ? ISR_RX :
            (ier_r[IER_THRE] && thrIntPend_r) ? ISR_THRE :
            (ier_r[IER_MS] && |msrDelta_r) ? ISR_MS : ISR_NONE;

        assign rdData[ch] =
            (hostAddr == ADDR_DATA) ? (dlab ? div_r[7:0] : rhr_r) :
            (hostAddr == ADDR_IER) ? (dlab ? div_r[15:8] : {4'h0, ier_r}) :
            (hostAddr == ADDR_ISR) ? isrCode :
            (hostAddr == ADDR_LCR) ? lcr_r :
            (hostAddr == ADDR_MCR) ? {3'h0, mcr_r} :
            (hostAddr == ADDR_LSR) ? lsr :
            (hostAddr == ADDR_MSR) ? {modemNow, msrDelta_r} : scr_r;

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
                irq_r <= 1'b0;
            else
                irq_r <= ~isrCode[0];
        end

        assign irq[ch] = irq_r;
        assign dtrN[ch] = ~mcr_r[MCR_DTR];
        assign rtsN[ch] = ~mcr_r[MCR_RTS];
    end
endmodule // dual_async_serial_port

// File: pkg/uart_pkg.sv
// shared constants, types and helpers for the dual serial port
package uart_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SCR = 3'h7;
    localparam int LCR_STOP = 2;
    localparam int LCR_PEN = 3;
    localparam int LCR_EVEN = 4;
    localparam int LCR_STICK = 5;
    localparam int LCR_BREAK = 6;
    localparam int LCR_DLAB = 7;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT1 = 2;
    localparam int MCR_OUT2 = 3;
    localparam int MCR_LOOP = 4;
    localparam int IER_RX = 0;
    localparam int IER_THRE = 1;
    localparam int IER_LS = 2;
    localparam int IER_MS = 3;
    localparam logic [7:0] ISR_LS = 8'h06;
    localparam logic [7:0] ISR_RX = 8'h04;
    localparam logic [7:0] ISR_THRE = 8'h02;
    localparam logic [7:0] ISR_MS = 8'h00;
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [4:0] MCR_RESET = 5'h00;
    localparam logic [3:0] IER_RESET = 4'h0;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam logic [3:0] BIT_LAST = 4'hF;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_PARITY = 5'h08, TX_STOP = 5'h10
    } txState_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_PARITY = 5'h08, RX_STOP = 5'h10
    } rxState_t;

    function automatic logic [7:0] charMask(input logic [1:0] wls);
        case (wls)
            2'h0: charMask = 8'h1F;
            2'h1: charMask = 8'h3F;
            2'h2: charMask = 8'h7F;
            default: charMask = 8'hFF;
        endcase
    endfunction

    function automatic logic parityBit(input logic [7:0] data, input logic [7:0] lcr);
        if (lcr[LCR_STICK])
            parityBit = ~lcr[LCR_EVEN];
        else
            parityBit = (^(data & charMask(lcr[1:0]))) ^ ~lcr[LCR_EVEN];
    endfunction
endpackage

// File: sim/dual_async_serial_port_checker.sv
// concurrent checks on the dual serial port's pins
`timescale 1ns/1ps
module dual_async_serial_port_checker
    import uart_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    input logic mclk,
    input logic rst,
    input logic [2:0] hostAddr,
    input logic hostWriteStrobeN,
    input logic hostReadStrobeN,
    input logic [CHANNELS-1:0] chipSelN,
    input logic [7:0] writeData,
    input logic [7:0] readData,
    input logic readDataEn,
    input logic readSelectOut,
    input logic [CHANNELS-1:0] serialTx,
    input logic [CHANNELS-1:0] dtrN,
    input logic [CHANNELS-1:0] rtsN,
    input logic [CHANNELS-1:0] irq
);
    logic wrA;
    logic wrB;
    logic rdAny;
    logic loopA_r;
    assign wrA = !hostWriteStrobeN && !chipSelN[0] && hostAddr == ADDR_MCR;
    assign wrB = !hostWriteStrobeN && !chipSelN[1] && hostAddr == ADDR_MCR;
    assign rdAny = !hostReadStrobeN && !(&chipSelN);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            loopA_r <= 1'b0;
        else if (wrA)
            loopA_r <= writeData[MCR_LOOP];
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_read_select_out_tracks: assert property (readSelectOut == rdAny)
        else $error("read select wrong");
    a_oe_matches: assert property (readDataEn == readSelectOut)
        else $error("bus enable wrong");
    a_reset_outputs: assert property ($fell(rst) |->
        (&serialTx) && (&dtrN) && (&rtsN) && irq == '0) else $error("pins not idle after reset");
    a_dtr_follows: assert property (wrA && !$past(wrA) |=>
        dtrN[0] == !$past(writeData[MCR_DTR])) else $error("terminal ready wrong");
    a_rts_follows: assert property (wrB && !$past(wrB) |=>
        rtsN[1] == !$past(writeData[MCR_RTS])) else $error("request to send wrong");
    a_dtr_only_written: assert property ($changed(dtrN[0]) |-> $past(wrA))
        else $error("terminal ready moved unwritten");
    a_loop_tx_mark: assert property (loopA_r && $past(loopA_r) |->
        serialTx[0]) else $error("output left mark in loopback");
    a_readdata_holds: assert property ($changed(readData) |->
        $past(rdAny) && !$past(rdAny, 2)) else $error("read data changed outside a read");
    a_start_bit_low: assert property ($fell(serialTx[0]) |-> (!serialTx[0]) [*8])
        else $error("start bit too short");

    c_read: cover property (rdAny && !$past(rdAny));
    c_mcr_write: cover property (wrA);
    c_tx_frame: cover property ($fell(serialTx[0]));
    c_irq: cover property ($rose(irq[0]));
endmodule // dual_async_serial_port_checker

bind dual_async_serial_port dual_async_serial_port_checker #(.CHANNELS(CHANNELS)) chk_u (
    .mclk(mclk), .rst(rst), .hostAddr(hostAddr), .hostWriteStrobeN(hostWriteStrobeN),
    .hostReadStrobeN(hostReadStrobeN), .chipSelN(chipSelN), .writeData(writeData),
    .readData(readData), .readDataEn(readDataEn), .readSelectOut(readSelectOut),
    .serialTx(serialTx), .dtrN(dtrN), .rtsN(rtsN), .irq(irq)
);

// File: sim/serial_line_model.sv
// far end of the serial line: decodes frames and sends characters
`timescale 1ns/1ps
module serial_line_model #(
    parameter int BIT_CYCLES = 16
)(
    input logic mclk,
    input logic lineIn,
    output logic lineOut,
    input logic forceSpace,
    input logic [3:0] nBits,
    input logic parEn,
    output logic [7:0] gotData,
    output logic gotPar,
    output logic gotStop,
    output logic gotDone
);
    logic txLvl = 1'b1;
    logic [7:0] rxShift;
    int k;
    assign lineOut = forceSpace ? 1'b0 : txLvl;
    initial
    begin
        gotDone = 1'b0;
        gotPar = 1'b0;
    end

    // one frame, data least significant bit first, one stop bit
    task automatic sendChar(input logic [7:0] d, input logic p);
        int i;
        @(posedge mclk);
        txLvl <= 1'b0;
        repeat (BIT_CYCLES) @(posedge mclk);
        for (i = 0; i < nBits; i++)
        begin
            txLvl <= d[i];
            repeat (BIT_CYCLES) @(posedge mclk);
        end
        if (parEn)
        begin
            txLvl <= p;
            repeat (BIT_CYCLES) @(posedge mclk);
        end
        txLvl <= 1'b1;
        repeat (BIT_CYCLES) @(posedge mclk);
    endtask

    // samples each bit at its centre
    always
    begin
        @(negedge lineIn);
        repeat (BIT_CYCLES / 2) @(posedge mclk);
        rxShift = 8'h00;
        for (k = 0; k < nBits; k++)
        begin
            repeat (BIT_CYCLES) @(posedge mclk);
            rxShift[k] = lineIn;
        end
        if (parEn)
        begin
            repeat (BIT_CYCLES) @(posedge mclk);
            gotPar <= lineIn;
        end
        repeat (BIT_CYCLES) @(posedge mclk);
        gotStop <= lineIn;
        gotData <= rxShift;
        gotDone <= 1'b1;
        @(posedge mclk);
        gotDone <= 1'b0;
    end
endmodule // serial_line_model

// File: sim/test_dual_async_serial_port.sv
// self-checking testbench for the dual serial port
`timescale 1ns/1ps
module test_dual_async_serial_port
    import uart_pkg::*;
;
    typedef struct {
        logic [9:0] e;
        logic [9:0] m;
    } note_t;
    logic mclk, rst, hostWriteStrobeN, hostReadStrobeN, readDataEn, readSelectOut;
    logic [2:0] hostAddr;
    logic [1:0] chipSelN, serialTx, ctsN, dsrN, riN, cdN, dtrN, rtsN, irq;
    logic [7:0] writeData, readData, gotData, rdVal, d, lcr, lenMask;
    logic [7:0] lcrTab [4];
    logic lineA, lineB, forceSpace, parEn, gotPar, gotStop, gotDone, rdPrev, rdPulse;
    logic [3:0] nBits;
    logic [1:0] i, j;
    wire [7:0] hostBus = readDataEn ? readData : 8'hZZ;
    note_t rdQ[$];
    note_t txQ[$];
    int errTotal, comparisons, seed, k, w;

    dual_async_serial_port #(.CHANNELS(2)) dut_u (
        .mclk(mclk), .rst(rst), .hostAddr(hostAddr), .hostWriteStrobeN(hostWriteStrobeN),
        .hostReadStrobeN(hostReadStrobeN), .chipSelN(chipSelN), .writeData(writeData),
        .readData(readData), .readDataEn(readDataEn), .readSelectOut(readSelectOut),
        .serialRx({lineB, lineA}), .serialTx(serialTx), .ctsN(ctsN), .dsrN(dsrN),
        .riN(riN), .cdN(cdN), .dtrN(dtrN), .rtsN(rtsN), .irq(irq)
    );
    serial_line_model #(.BIT_CYCLES(16)) line_u (
        .mclk(mclk), .lineIn(serialTx[0]), .lineOut(lineA), .forceSpace(forceSpace),
        .nBits(nBits), .parEn(parEn), .gotData(gotData), .gotPar(gotPar),
        .gotStop(gotStop), .gotDone(gotDone)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic reportAndStop();
        $display("comparisons %0d errors %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic take(ref note_t q[$], input logic [9:0] seen, input string what);
        note_t n;
        n = '{10'h3FF, 10'h3FF};
        if (q.size() > 0)
            n = q.pop_front();
        chk(seen & n.m, n.e & n.m, what);
    endtask

    task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] v);
        @(negedge mclk);
        chipSelN = ~(2'b01 << ch);
        hostAddr = a;
        writeData = v;
        hostWriteStrobeN = 1'b0;
        @(negedge mclk);
        hostWriteStrobeN = 1'b1;
        chipSelN = 2'b11;
        writeData = $random(seed);
    endtask

    task automatic rd(input int ch, input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        rdQ.push_back('{{2'b00, e}, {2'b00, m}});
        @(negedge mclk);
        chipSelN = ~(2'b01 << ch);
        hostAddr = a;
        hostReadStrobeN = 1'b0;
        @(negedge mclk);
        rdVal = hostBus;
        @(negedge mclk);
        hostReadStrobeN = 1'b1;
        chipSelN = 2'b11;
    endtask

    function automatic logic par(input logic [7:0] v, input logic [7:0] l);
        par = (^v) ^ !l[LCR_EVEN];
    endfunction

    // answer watcher
    always @(posedge mclk)
    begin
        rdPulse <= readSelectOut && !rdPrev;
        rdPrev <= readSelectOut;
    end
    always @(negedge mclk)
    begin
        if (rdPulse === 1'b1)
            take(rdQ, {2'b00, hostBus}, "read data");
        if (gotDone === 1'b1)
            take(txQ, {gotStop, gotPar, gotData}, "serial frame");
    end

    initial
    begin
        seed = 14;
        errTotal = 0;
        comparisons = 0;
        rst = 1'b1;
        hostAddr = 3'h0;
        hostWriteStrobeN = 1'b1;
        hostReadStrobeN = 1'b1;
        chipSelN = 2'b11;
        writeData = 8'h00;
        lineB = 1'b1;
        ctsN = 2'b11;
        {dsrN, riN, cdN} = $random(seed);
        forceSpace = 1'b0;
        parEn = 1'b0;
        nBits = 4'h8;
        lcrTab = '{8'h03, 8'h1A, 8'h09, 8'h04};
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        chk({serialTx, dtrN, rtsN, irq}, 8'hFC, "idle pins");
        rd(0, ADDR_LCR, LCR_RESET, 8'hFF);
        rd(0, ADDR_MCR, {3'h0, MCR_RESET}, 8'h1F);
        rd(0, ADDR_ISR, ISR_NONE, 8'h0F);
        for (k = 0; k < 4; k++)
        begin
            i = k;
            j = 2'h3 - i;
            wr(0, ADDR_MCR, {6'h00, i});
            wr(1, ADDR_MCR, {6'h00, j});
            chk({dtrN, rtsN}, {~j[0], ~i[0], ~j[1], ~i[1]}, "modem out");
        end
        ctsN = 2'b10;
        rd(0, ADDR_MSR, 8'h10, 8'h10);
        rd(1, ADDR_MSR, 8'h00, 8'h10);
        wr(0, ADDR_LCR, 8'h80);
        wr(0, ADDR_DATA, 8'h01);
        wr(0, ADDR_IER, 8'h00);
        rd(0, ADDR_DATA, 8'h01, 8'hFF);
        rd(0, ADDR_IER, 8'h00, 8'hFF);
        for (k = 0; k < 4; k++)
        begin
            lcr = lcrTab[k];
            nBits = 4'h5 + lcr[1:0];
            parEn = lcr[LCR_PEN];
            lenMask = 8'hFF >> (4'h8 - nBits);
            wr(0, ADDR_LCR, lcr);
            {dsrN, riN, cdN, ctsN} = $random(seed);
            d = $random(seed) & lenMask;
            txQ.push_back('{{1'b1, par(d, lcr), d}, {1'b1, parEn, 8'hFF}});
            wr(0, ADDR_DATA, d);
            for (w = 0; w < 2000 && txQ.size() != 0; w++)
                @(negedge mclk);
            chk(txQ.size() != 0, 1'b0, "frame wait");
            if (txQ.size() != 0)
                reportAndStop();
            if (k == 1)
                wr(0, ADDR_IER, 8'h01);
            d = $random(seed) & lenMask;
            line_u.sendChar(d, par(d, lcr));
            rd(0, ADDR_LSR, 8'h01, 8'h1F);
            chk(irq[0], k == 1, "interrupt");
            rd(0, ADDR_ISR, (k == 1) ? ISR_RX : ISR_NONE, 8'h0F);
            rd(0, ADDR_DATA, d, 8'hFF);
            repeat (2) @(negedge mclk);
            chk(irq[0], 1'b0, "interrupt clear");
            wr(0, ADDR_IER, 8'h00);
            if (parEn)
            begin
                line_u.sendChar(d, !par(d, lcr));
                rd(0, ADDR_LSR, 8'h05, 8'h1F);
                rd(0, ADDR_DATA, d, 8'hFF);
            end
        end
        nBits = 4'h8;
        parEn = 1'b0;
        wr(0, ADDR_LCR, 8'h03);
        wr(0, ADDR_MCR, 8'h10);
        forceSpace = 1'b1;
        d = $random(seed);
        wr(0, ADDR_DATA, d);
        for (w = 0; w < 200; w++)
        begin
            rd(0, ADDR_LSR, 8'h00, 8'h00);
            if (rdVal[0] === 1'b1)
                break;
        end
        chk(rdVal[0], 1'b1, "loop wait");
        rd(0, ADDR_DATA, d, 8'hFF);
        forceSpace = 1'b0;
        wr(0, ADDR_MCR, 8'h03);
        rst = 1'b1;
        @(negedge mclk);
        chk({serialTx, dtrN, rtsN, irq}, 8'hFC, "reset pins");
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk(rdQ.size() != 0, 1'b0, "reads answered");
        reportAndStop();
    end
endmodule // test_dual_async_serial_port
